/* File: verilog/seq_pkg.sv */
/*
 * Shared constants and types for the handset power sequencer.
 * Assumes a 200 MHz system clock; all timer counts derive from it.
 */
package seq_pkg;
    localparam int unsigned CLK_MHZ = 200;
    // Timer figures in their own units.
    localparam int unsigned DEBOUNCE_MS = 32;
    localparam int unsigned RESET_DELAY_MS = 20;
    localparam int unsigned REG_DELAY_STD_US = 125;
    localparam int unsigned REG_DELAY_OPT_MS = 10;
    localparam int unsigned HOLD_WINDOW_MS = 500;
    localparam int unsigned FLAG_FILTER_US = 6;
    // Cycle counts derived from the figures.
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
    localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * 1000 * CLK_MHZ;
    localparam int unsigned REG_DELAY_STD_CYC = REG_DELAY_STD_US * CLK_MHZ;
    localparam int unsigned REG_DELAY_OPT_CYC = REG_DELAY_OPT_MS * 1000 * CLK_MHZ;
    localparam int unsigned HOLD_WINDOW_CYC = HOLD_WINDOW_MS * 1000 * CLK_MHZ;
    localparam int unsigned FLAG_FILTER_CYC = FLAG_FILTER_US * CLK_MHZ;
    localparam int unsigned TIMER_W = 28;

    typedef enum logic [3:0] {
        ST_OFF = 4'h0,
        ST_PRI_ON = 4'h1,
        ST_PRI_WAIT = 4'h2,
        ST_SEC_ON = 4'h3,
        ST_RST_WAIT = 4'h4,
        ST_HOLD_WAIT = 4'h5,
        ST_RUN = 4'h6,
        ST_DN_RST = 4'h7,
        ST_DN_SEC = 4'h8,
        ST_DN_PRI = 4'h9
    } seq_state_t;

    typedef struct packed {
        logic primary_en;
        logic secondary_en;
        logic sys_reset_n;
        logic key_irq_n;
    } seq_out_t;

    localparam seq_out_t OUT_RESET = '{primary_en: 1'b0, secondary_en: 1'b0, sys_reset_n: 1'b0, key_irq_n: 1'b1};
endpackage

/* File: verilog/debounce.sv */
/*
 * Debouncer: output follows the input only after it has stayed steady
 * for the full count. Assumes the input is already synchronised.
 */
`timescale 1ns/1ps
module debounce #(
    parameter int unsigned COUNT = 6400000,
    parameter logic INIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    localparam int unsigned W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_r;
    logic dout_r;
    wire differ = (din != dout_r);
    wire done = (cnt_r == W'(COUNT - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            dout_r <= INIT;
        end else if (!differ) begin
            cnt_r <= '0;
        end else if (done) begin
            cnt_r <= '0;
            dout_r <= din;
        end else begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    assign dout = dout_r;
endmodule

/* File: verilog/power_sequencer.sv */
/*
 * Power sequencer for two regulators: debounced start inputs, ordered
 * enable, reset release and hold-window supervision.
 * Assumes the comparator outputs and pins are synchronous-ish levels;
 * they pass through two flip-flops anyway before use.
 */
`timescale 1ns/1ps
// How it works
// - Comparator rise at rise threshold sets flag.
// - Comparator fall threshold clears flag, hysteresis.
// - Output-good flags stay internal, no port.
// - Flags follow comparators within ten microseconds.
// - Key and charger accepted after debounce.
// - Reset released after reset delay.
// - Secondary disabled reset delay after reset.
// - Secondary enabled regulator delay after primary.
// - Primary disabled regulator delay after secondary.
// - Variant selects the longer regulator delay.
// - Hold window timed from reset release.
// - Key start asserts interrupt until hold, charger or timeout.
// - Hold window expiry forces full power-down.
// - Hold low shuts down in reverse order.
// - Charger starts silently, blocks hold shutdown.
module power_sequencer #(
    parameter int unsigned DEBOUNCE_CYC = seq_pkg::DEBOUNCE_CYC,
    parameter int unsigned RESET_DELAY_CYC = seq_pkg::RESET_DELAY_CYC,
    parameter int unsigned REG_DELAY_OPT_CYC = seq_pkg::REG_DELAY_OPT_CYC,
    parameter int unsigned HOLD_WINDOW_CYC = seq_pkg::HOLD_WINDOW_CYC,
    parameter int unsigned REG_DELAY_STD_CYC = seq_pkg::REG_DELAY_STD_CYC,
    parameter int unsigned FLAG_FILTER_CYC = seq_pkg::FLAG_FILTER_CYC,
    parameter logic LONG_REG_DELAY = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic power_key_in,
    input wire logic charger_detect_n,
    input wire logic power_hold_in,
    input wire logic primary_above_rise,
    input wire logic primary_below_fall,
    input wire logic secondary_above_rise,
    input wire logic secondary_below_fall,
    output logic primary_regulator_en,
    output logic secondary_regulator_en,
    output logic sys_reset_n,
    output logic key_irq_n
);
    localparam int unsigned TW = seq_pkg::TIMER_W;

    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    localparam int NIN = 7;
    wire [NIN-1:0] raw_in = {power_key_in, charger_detect_n, power_hold_in, primary_above_rise,
                             primary_below_fall, secondary_above_rise, secondary_below_fall};
    localparam logic [NIN-1:0] IN_INIT = 7'h20;
    logic [NIN-1:0] meta_r;
    logic [NIN-1:0] sync_r;
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r[gi] <= IN_INIT[gi];
                    sync_r[gi] <= IN_INIT[gi];
                end else begin
                    meta_r[gi] <= raw_in[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate
    wire key_s = sync_r[6];
    wire chg_n_s = sync_r[5];
    wire hold_s = sync_r[4];
    wire [1:0] above_s = {sync_r[3], sync_r[1]};
    wire [1:0] below_s = {sync_r[2], sync_r[0]};

    logic key_db;
    logic chg_n_db;
    debounce #(.COUNT(DEBOUNCE_CYC), .INIT(1'b0)) u_key_db (
        .clk(clk),
        .rst_n(rst_n),
        .din(key_s),
        .dout(key_db)
    );
    debounce #(.COUNT(DEBOUNCE_CYC), .INIT(1'b1)) u_chg_db (
        .clk(clk),
        .rst_n(rst_n),
        .din(chg_n_s),
        .dout(chg_n_db)
    );

    // Flags: index 1 primary, 0 secondary. A short glitch filter keeps
    // comparator chatter out while staying well inside ten microseconds.
    logic [1:0] flag_r;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_flag
            logic [TW-1:0] fcnt_r;
            wire want_set = above_s[gi] && !flag_r[gi];
            wire want_clr = below_s[gi] && flag_r[gi];
            wire want = want_set || want_clr;
            wire fdone = (fcnt_r == TW'(FLAG_FILTER_CYC - 1));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    fcnt_r <= '0;
                    flag_r[gi] <= 1'b0;
                end else if (!want) begin
                    fcnt_r <= '0;
                end else if (fdone) begin
                    fcnt_r <= '0;
                    flag_r[gi] <= want_set;
                end else begin
                    fcnt_r <= fcnt_r + TW'(1);
                end
            end
        end
    endgenerate
    wire pri_good = flag_r[1];
    wire sec_good = flag_r[0];

    localparam int unsigned REG_CYC = LONG_REG_DELAY ? REG_DELAY_OPT_CYC : REG_DELAY_STD_CYC;

    seq_pkg::seq_state_t state_r;
    seq_pkg::seq_state_t state_nxt;
    seq_pkg::seq_out_t out_r;
    seq_pkg::seq_out_t out_nxt;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] tmr_nxt;
    logic key_db_d_r;
    logic chg_n_db_d_r;

    wire key_rise = key_db && !key_db_d_r;
    wire chg_fall = !chg_n_db && chg_n_db_d_r;
    wire tmr_zero = (tmr_r == '0);
    wire on_charger = !chg_n_db;
    wire host_off = !hold_s && !on_charger;
    wire rail_lost = !pri_good || !sec_good;

    always_comb begin
        state_nxt = state_r;
        out_nxt = out_r;
        tmr_nxt = tmr_zero ? tmr_r : tmr_r - TW'(1);
        case (state_r)
            seq_pkg::ST_OFF: begin
                if (key_rise || chg_fall) begin
                    out_nxt.key_irq_n = !key_rise;
                    out_nxt.primary_en = 1'b1;
                    state_nxt = seq_pkg::ST_PRI_ON;
                end
            end
            seq_pkg::ST_PRI_ON: begin
                if (pri_good) begin
                    tmr_nxt = TW'(REG_CYC);
                    state_nxt = seq_pkg::ST_PRI_WAIT;
                end
            end
            seq_pkg::ST_PRI_WAIT: begin
                if (tmr_zero) begin
                    out_nxt.secondary_en = 1'b1;
                    state_nxt = seq_pkg::ST_SEC_ON;
                end
            end
            seq_pkg::ST_SEC_ON: begin
                if (sec_good) begin
                    tmr_nxt = TW'(RESET_DELAY_CYC);
                    state_nxt = seq_pkg::ST_RST_WAIT;
                end
            end
            seq_pkg::ST_RST_WAIT: begin
                if (tmr_zero) begin
                    out_nxt.sys_reset_n = 1'b1;
                    tmr_nxt = TW'(HOLD_WINDOW_CYC);
                    state_nxt = seq_pkg::ST_HOLD_WAIT;
                end
            end
            seq_pkg::ST_HOLD_WAIT: begin
                if (hold_s || on_charger) begin
                    out_nxt.key_irq_n = 1'b1;
                    state_nxt = seq_pkg::ST_RUN;
                end else if (tmr_zero) begin
                    out_nxt.key_irq_n = 1'b1;
                    out_nxt.sys_reset_n = 1'b0;
                    tmr_nxt = TW'(RESET_DELAY_CYC);
                    state_nxt = seq_pkg::ST_DN_RST;
                end
            end
            seq_pkg::ST_RUN: begin
                if (host_off || rail_lost) begin
                    out_nxt.sys_reset_n = 1'b0;
                    tmr_nxt = TW'(RESET_DELAY_CYC);
                    state_nxt = seq_pkg::ST_DN_RST;
                end
            end
            seq_pkg::ST_DN_RST: begin
                if (tmr_zero) begin
                    out_nxt.secondary_en = 1'b0;
                    state_nxt = seq_pkg::ST_DN_SEC;
                end
            end
            seq_pkg::ST_DN_SEC: begin
                if (!sec_good) begin
                    tmr_nxt = TW'(REG_CYC);
                    state_nxt = seq_pkg::ST_DN_PRI;
                end
            end
            seq_pkg::ST_DN_PRI: begin
                if (tmr_zero) begin
                    out_nxt.primary_en = 1'b0;
                    state_nxt = seq_pkg::ST_OFF;
                end
            end
            default: begin
                out_nxt = seq_pkg::OUT_RESET;
                state_nxt = seq_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= seq_pkg::ST_OFF;
            out_r <= seq_pkg::OUT_RESET;
            tmr_r <= '0;
            key_db_d_r <= 1'b0;
            chg_n_db_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            out_r <= out_nxt;
            tmr_r <= tmr_nxt;
            key_db_d_r <= key_db;
            chg_n_db_d_r <= chg_n_db;
        end
    end

    assign primary_regulator_en = out_r.primary_en;
    assign secondary_regulator_en = out_r.secondary_en;
    assign sys_reset_n = out_r.sys_reset_n;
    assign key_irq_n = out_r.key_irq_n;
endmodule

/* File: tb/seq_asserts.sv */
/* Port checker for the power sequencer.
   Assumes it is bound into power_sequencer with the same timer counts. */
`timescale 1ns/1ps
module seq_asserts #(
    parameter int unsigned DEBOUNCE_CYC = 20,
    parameter int unsigned RESET_DELAY_CYC = 30,
    parameter int unsigned REG_DELAY_STD_CYC = 10,
    parameter int unsigned HOLD_WINDOW_CYC = 100
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic power_key_in,
    input wire logic charger_detect_n,
    input wire logic power_hold_in,
    input wire logic primary_regulator_en,
    input wire logic secondary_regulator_en,
    input wire logic sys_reset_n,
    input wire logic key_irq_n
);
    logic [15:0] key_r, chg_r, pri_r, sec_r, rlo_r, soff_r, hold_r;
    // Run lengths saturate so a long idle never wraps into a false short count.
    function automatic logic [15:0] run(input logic c, input logic [15:0] n);
        return !c ? 16'h0000 : (n == 16'hffff) ? n : n + 16'h0001;
    endfunction
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {key_r, chg_r, pri_r, sec_r} <= '0;
            {rlo_r, soff_r, hold_r} <= '0;
        end else begin
            key_r <= run(power_key_in, key_r);
            chg_r <= run(!charger_detect_n, chg_r);
            pri_r <= run(primary_regulator_en, pri_r);
            sec_r <= run(secondary_regulator_en, sec_r);
            rlo_r <= run(!sys_reset_n, rlo_r);
            soff_r <= run(!secondary_regulator_en, soff_r);
            hold_r <= run(sys_reset_n && !power_hold_in && charger_detect_n, hold_r);
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_reset_safe: assert property (
        $rose(reset_n) |-> !primary_regulator_en && !secondary_regulator_en && !sys_reset_n && key_irq_n)
        else $error("outputs unsafe after reset");
    a_start_debounced: assert property (
        $rose(primary_regulator_en) |-> key_r >= DEBOUNCE_CYC || chg_r >= DEBOUNCE_CYC)
        else $error("start without debounce");
    a_sec_needs_pri: assert property (secondary_regulator_en |-> primary_regulator_en)
        else $error("secondary on without primary");
    a_rst_needs_sec: assert property (sys_reset_n |-> secondary_regulator_en)
        else $error("reset released without secondary");
    a_sec_on_delay: assert property ($rose(secondary_regulator_en) |-> pri_r >= REG_DELAY_STD_CYC)
        else $error("secondary enabled early");
    a_rst_up_delay: assert property ($rose(sys_reset_n) |-> sec_r >= RESET_DELAY_CYC)
        else $error("reset released early");
    a_sec_off_delay: assert property ($fell(secondary_regulator_en) |-> rlo_r >= RESET_DELAY_CYC)
        else $error("secondary disabled early");
    a_pri_off_delay: assert property ($fell(primary_regulator_en) |-> soff_r >= REG_DELAY_STD_CYC)
        else $error("primary disabled early");
    a_hold_expiry: assert property (hold_r <= HOLD_WINDOW_CYC + 8)
        else $error("hold window overrun");
    a_irq_clear: assert property (
        !key_irq_n && sys_reset_n && power_hold_in |-> ##[1:4] key_irq_n)
        else $error("interrupt not cleared");
    a_irq_start: assert property ($fell(key_irq_n) |-> ##[0:3] primary_regulator_en && !sys_reset_n)
        else $error("interrupt without start");
    a_hold_drop: assert property (
        $fell(power_hold_in) && sys_reset_n && chg_r == 16'h0000 |-> ##[1:6] !sys_reset_n)
        else $error("hold drop ignored");
    c_release: cover property ($rose(sys_reset_n));
    c_full_off: cover property ($fell(primary_regulator_en));
    c_irq_done: cover property ($rose(key_irq_n) && sys_reset_n);
endmodule

/* File: tb/host_model.sv */
/* Host processor model driving the hold input.
   Assumes the bench sets respond and dly between power cycles and raises drop while running. */
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    input wire logic sys_reset_n,
    input wire logic respond,
    input wire logic drop,
    input wire logic [7:0] dly,
    output logic power_hold_in
);
    logic [7:0] wait_r = 8'h00;
    initial power_hold_in = 1'b0;
    always @(posedge clk) begin
        if (!sys_reset_n) begin
            wait_r <= 8'h00;
            power_hold_in <= 1'b0;
        end else begin
            wait_r <= (wait_r == 8'hff) ? wait_r : wait_r + 8'h01;
            power_hold_in <= respond && !drop && wait_r >= dly;
        end
    end
endmodule

/* File: tb/handset_power_sequencer_tb.sv */
/* Self-checking bench for the power sequencer with short timer counts.
   Assumes seq_pkg, power_sequencer, host_model and seq_asserts compile first. */
`timescale 1ns/1ps
bind power_sequencer seq_asserts #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .RESET_DELAY_CYC(RESET_DELAY_CYC),
    .REG_DELAY_STD_CYC(REG_DELAY_STD_CYC), .HOLD_WINDOW_CYC(HOLD_WINDOW_CYC)) u_chk (.clk, .reset_n,
    .power_key_in, .charger_detect_n, .power_hold_in, .primary_regulator_en, .secondary_regulator_en,
    .sys_reset_n, .key_irq_n);
module handset_power_sequencer_tb;
    localparam int DEB = 20;
    localparam int RSTD = 30;
    localparam int REGD = 10;
    localparam int HOLDW = 100;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic power_key_in = 1'b0;
    logic charger_detect_n = 1'b1;
    logic respond = 1'b0;
    logic drop = 1'b0;
    logic [7:0] dly = 8'h05;
    logic [2:0] pri_d = 3'h0;
    logic [2:0] sec_d = 3'h0;
    logic power_hold_in, pe, se, rn, irq;
    seq_pkg::seq_out_t outs;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc;
    assign outs = {pe, se, rn, irq};
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Regulator outputs cross their thresholds three cycles after a change of enable.
    always @(posedge clk) begin
        pri_d <= {pri_d[1:0], pe};
        sec_d <= {sec_d[1:0], se};
    end
    power_sequencer #(.DEBOUNCE_CYC(DEB), .RESET_DELAY_CYC(RSTD), .REG_DELAY_OPT_CYC(40),
        .HOLD_WINDOW_CYC(HOLDW), .REG_DELAY_STD_CYC(REGD), .FLAG_FILTER_CYC(4), .LONG_REG_DELAY(1'b0)) DUT (
        .clk, .reset_n, .power_key_in, .charger_detect_n, .power_hold_in,
        .primary_above_rise(pri_d[2]), .primary_below_fall(!pri_d[2]),
        .secondary_above_rise(sec_d[2]), .secondary_below_fall(!sec_d[2]),
        .primary_regulator_en(pe), .secondary_regulator_en(se), .sys_reset_n(rn), .key_irq_n(irq));
    host_model u_host (.clk, .sys_reset_n(rn), .respond, .drop, .dly, .power_hold_in);
    // Output levels after the given number of power-up steps.
    function automatic seq_pkg::seq_out_t lvl(input int step, input logic irq_n);
        return {step > 0, step > 1, step > 2, irq_n};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wait_out(input string what, input seq_pkg::seq_out_t w, input int lim);
        cyc = 0;
        while (outs !== w && cyc < lim) begin
            @(negedge clk);
            cyc++;
        end
        check(what, outs, w);
    endtask
    task automatic key_start;
        @(posedge clk);
        power_key_in <= 1'b1;
        wait_out("key start", lvl(1, 1'b0), DEB + 10);
        check("debounce", cyc >= DEB, 1);
        @(posedge clk);
        power_key_in <= 1'b0;
        wait_out("sec on", lvl(2, 1'b0), REGD + 20);
        check("reg delay", cyc >= REGD, 1);
        wait_out("reset off", lvl(3, 1'b0), RSTD + 20);
        check("reset delay", cyc >= RSTD, 1);
    endtask
    task automatic power_down;
        wait_out("sec off", lvl(1, 1'b1), RSTD + 10);
        check("rst to sec", cyc >= RSTD - 1, 1);
        wait_out("pri off", lvl(0, 1'b1), REGD + 20);
        check("sec to pri", cyc >= REGD, 1);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        summarize();
    end
    initial begin
        void'($urandom(86883));
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(negedge clk);
        check("reset", outs, lvl(0, 1'b1));
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            power_key_in <= 1'b1;
            repeat (i == 0 ? DEB - 3 : $urandom_range(DEB - 4, 1)) @(posedge clk);
            power_key_in <= 1'b0;
            repeat (DEB + 8) @(negedge clk);
            check("short key", outs, lvl(0, 1'b1));
        end
        $display("test short key done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            respond <= 1'b1;
            dly <= 8'(i == 0 ? HOLDW - 12 : $urandom_range(60, 2));
            key_start();
            wait_out("hold up", lvl(3, 1'b1), HOLDW);
            @(posedge clk);
            drop <= 1'b1;
            wait_out("hold drop", lvl(2, 1'b1), 8);
            power_down();
            @(posedge clk);
            drop <= 1'b0;
        end
        $display("test hold done");
        @(posedge clk);
        respond <= 1'b0;
        key_start();
        wait_out("expiry", lvl(2, 1'b1), HOLDW + 20);
        check("window", cyc >= HOLDW - 4, 1);
        power_down();
        $display("test expiry done");
        @(posedge clk);
        respond <= 1'b1;
        dly <= 8'h05;
        charger_detect_n <= 1'b0;
        wait_out("chg start", lvl(1, 1'b1), DEB + 10);
        wait_out("chg run", lvl(3, 1'b1), RSTD + REGD + 40);
        @(posedge clk);
        drop <= 1'b1;
        repeat (HOLDW + 20) @(negedge clk);
        check("chg hold", outs, lvl(3, 1'b1));
        @(posedge clk);
        charger_detect_n <= 1'b1;
        wait_out("chg off", lvl(2, 1'b1), DEB + 10);
        power_down();
        $display("test charger done");
        summarize();
    end
endmodule
